/* File: rtl/rtch_pkg.sv */
package rtch_pkg;

  // ----------------------------------------------------------------
  // instruction byte fields
  // ----------------------------------------------------------------
  localparam int BIT_CMD    = 6;
  localparam int BIT_WRITE  = 5;
  localparam int BIT_VERIFY = 4;
  localparam int BIT_ACK    = 3;
  localparam int BIT_INC    = 2;

  // ----------------------------------------------------------------
  // reply status codes
  // ----------------------------------------------------------------
  localparam logic [7:0] STAT_OK      = 8'h00;
  localparam logic [7:0] STAT_GENERAL = 8'h01;
  localparam logic [7:0] STAT_UNUSED  = 8'h02;
  localparam logic [7:0] STAT_KEY     = 8'h03;
  localparam logic [7:0] STAT_CARGO   = 8'h06;
  localparam logic [7:0] STAT_VER_OVR = 8'h09;
  localparam logic [7:0] STAT_AUTH    = 8'h0a;
  localparam logic [7:0] STAT_RMW_LEN = 8'h0b;

  // ----------------------------------------------------------------
  // lengths and buffer sizing
  // ----------------------------------------------------------------
  localparam logic [23:0] RMW_LEN_2   = 24'h000002;
  localparam logic [23:0] RMW_LEN_4   = 24'h000004;
  localparam logic [23:0] RMW_LEN_8   = 24'h000008;
  localparam logic [23:0] RMW_LEN_BAD = 24'h000006;
  localparam logic [23:0] VER_MAX_LEN = 24'h000004;
  localparam logic [23:0] WORD_BYTES  = 24'h000004;
  localparam logic [31:0] ADDR_STEP   = 32'h00000004;
  localparam int          BUF_DEPTH   = 4;
  localparam int          PTR_W       = 2;
  localparam logic [2:0]  CNT_FULL    = 3'h4;
  localparam logic [2:0]  CNT_ONE     = 3'h1;

  // decoded command header plus first data word
  typedef struct packed {
    logic [7:0]  instr;
    logic [7:0]  key;
    logic [31:0] addr;
    logic [23:0] len;
    logic [31:0] data;
    logic [31:0] mask;
    logic        cargo_big;
  } rtch_cmd_type;

  // one pending reply
  typedef struct packed {
    logic [7:0]  instr;
    logic [7:0]  status;
    logic [31:0] addr;
    logic [23:0] len;
    logic [31:0] rdata;
  } rtch_reply_type;

  // bus request
  typedef struct packed {
    logic        write;
    logic [31:0] addr;
    logic [2:0]  size;
    logic [31:0] wdata;
  } rtch_bus_type;

endpackage

/* File: rtl/rtch_target.sv */
`timescale 1ns/100ps
module rtch_target
  import rtch_pkg::*;
(
  // clock and reset
  input  wire logic           mclk_i,
  input  wire logic           rst_n_i,
  // control
  input  wire logic           tgt_enable_i,
  input  wire logic           buf_disable_i,
  input  wire logic [7:0]     dest_key_i,
  // incoming command
  input  wire logic           cmd_valid_i,
  input  wire rtch_cmd_type   cmd_i,
  output logic                cmd_ready_o,
  output logic                dma_fwd_o,
  // bus master
  output logic                bus_req_o,
  output rtch_bus_type        bus_o,
  input  wire logic           bus_ack_i,
  input  wire logic           bus_err_i,
  input  wire logic [31:0]    bus_rdata_i,
  // reply stream
  output logic                rep_hdr_valid_o,
  output rtch_reply_type      rep_hdr_o,
  output logic                rep_data_valid_o,
  output logic [31:0]         rep_data_o,
  output logic                rep_last_o,
  output logic                rep_abort_o,
  input  wire logic           rep_ready_i
);

  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE   = 7'b0000001,
    ST_RMW_RD = 7'b0000010,
    ST_BUS_WR = 7'b0000100,
    ST_TX_HDR = 7'b0001000,
    ST_TX_RD  = 7'b0010000,
    ST_TX_BT  = 7'b0100000,
    ST_SETTLE = 7'b1000000
  } rtch_state_type;

  rtch_state_type             state;
  rtch_cmd_type               cur;
  rtch_reply_type             ring [BUF_DEPTH];
  logic [PTR_W-1:0]           wr_ptr;
  logic [PTR_W-1:0]           rd_ptr;
  logic [2:0]                 count;
  logic                       enq;
  rtch_reply_type             enq_entry;
  logic                       deq;
  logic [23:0]                remain;
  logic [31:0]                old_data;
  logic [7:0]                 chk;
  logic                       ignore;
  logic                       has_space;
  logic                       is_rmw;

  // ----------------------------------------------------------------
  // command classification
  // ----------------------------------------------------------------
  function automatic logic align_bad(input logic [31:0] a, input logic [23:0] n);
    logic r;
    r = 1'b0;
    case (n)
      24'h000001: r = 1'b0;
      24'h000002: r = a[0];
      24'h000004: r = |a[1:0];
      default:    r = 1'b1; // 3 bytes never allowed
    endcase
    return r;
  endfunction

  // status found at decode; bus errors and cargo size come later
  always_comb
  begin
    logic w, v, a, i;
    w      = cmd_i.instr[BIT_WRITE];
    v      = cmd_i.instr[BIT_VERIFY];
    a      = cmd_i.instr[BIT_ACK];
    i      = cmd_i.instr[BIT_INC];
    chk    = STAT_OK;
    ignore = 1'b0;
    is_rmw = !w && v && a && i;
    if (!w && v && !(a && i))
    begin
      chk    = STAT_UNUSED;
      ignore = !a;
    end
    else if (cmd_i.key != dest_key_i)
      chk = STAT_KEY;
    else if (is_rmw)
    begin
      if (cmd_i.len == RMW_LEN_BAD || !(cmd_i.len == RMW_LEN_2 ||
          cmd_i.len == RMW_LEN_4 || cmd_i.len == RMW_LEN_8))
        chk = STAT_RMW_LEN;
      else if (align_bad(cmd_i.addr, cmd_i.len >> 1))
        chk = STAT_AUTH;
    end
    else if (w && v)
    begin
      if (cmd_i.len > VER_MAX_LEN)
        chk = STAT_VER_OVR;
      else if (align_bad(cmd_i.addr, cmd_i.len))
        chk = STAT_AUTH;
    end
    else if (!i && (|cmd_i.addr[1:0] || |cmd_i.len[1:0]))
      chk = STAT_AUTH;
  end

  // only one entry counts as room when the buffer is disabled
  assign has_space = buf_disable_i ? (count == 3'h0) : (count != CNT_FULL);

  // ----------------------------------------------------------------
  // reply ring
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= 3'h0;
    end
    else
    begin
      if (enq)
        wr_ptr <= wr_ptr + 1'b1;
      if (deq)
        rd_ptr <= rd_ptr + 1'b1;
      count <= count + {2'h0, enq} - {2'h0, deq};
    end
  end

  // entry storage, no reset needed
  always_ff @(posedge mclk_i)
  begin
    if (enq)
      ring[wr_ptr] <= enq_entry;
  end

  // ----------------------------------------------------------------
  // sequencer: execution and reply transmission
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state            <= ST_IDLE;
      cur              <= '0;
      enq              <= 1'b0;
      enq_entry        <= '0;
      deq              <= 1'b0;
      remain           <= 24'h0;
      old_data         <= 32'h0;
      cmd_ready_o      <= 1'b0;
      dma_fwd_o        <= 1'b0;
      bus_req_o        <= 1'b0;
      bus_o            <= '0;
      rep_hdr_valid_o  <= 1'b0;
      rep_hdr_o        <= '0;
      rep_data_valid_o <= 1'b0;
      rep_data_o       <= 32'h0;
      rep_last_o       <= 1'b0;
      rep_abort_o      <= 1'b0;
    end
    else
    begin
      cmd_ready_o <= 1'b0;
      dma_fwd_o   <= 1'b0;
      enq         <= 1'b0;
      deq         <= 1'b0;
      rep_abort_o <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (count != 3'h0 && (!cmd_valid_i || !has_space || !tgt_enable_i))
          begin
            rep_hdr_o       <= ring[rd_ptr];
            rep_hdr_valid_o <= 1'b1;
            state           <= ST_TX_HDR;
          end
          else if (cmd_valid_i && (!tgt_enable_i || !cmd_i.instr[BIT_CMD]))
          begin
            cmd_ready_o <= 1'b1; // whole packet to DMA
            dma_fwd_o   <= 1'b1;
            state       <= ST_SETTLE;
          end
          else if (cmd_valid_i && has_space)
          begin
            cmd_ready_o     <= 1'b1;
            cur             <= cmd_i;
            enq_entry.instr <= cmd_i.instr;
            enq_entry.status<= chk;
            enq_entry.addr  <= cmd_i.addr;
            enq_entry.len   <= cmd_i.len;
            enq_entry.rdata <= 32'h0;
            bus_o.addr      <= cmd_i.addr;
            bus_o.wdata     <= cmd_i.data;
            state           <= ST_SETTLE;
            if (ignore)
              state <= ST_SETTLE; // nothing done
            else if (chk != STAT_OK)
              enq <= cmd_i.instr[BIT_ACK]; // no execution
            else if (is_rmw)
            begin
              bus_req_o   <= 1'b1; // one read then one write
              bus_o.write <= 1'b0;
              bus_o.size  <= cmd_i.len[3:1];
              state       <= ST_RMW_RD;
            end
            else if (cmd_i.instr[BIT_WRITE])
            begin
              bus_req_o   <= 1'b1;
              bus_o.write <= 1'b1;
              bus_o.size  <= (cmd_i.len > VER_MAX_LEN) ? 3'h4 : cmd_i.len[2:0];
              state       <= ST_BUS_WR;
            end
            else
              enq <= cmd_i.instr[BIT_ACK]; // read queued, data later
          end
        end
        ST_RMW_RD:
        begin
          if (bus_ack_i)
          begin
            old_data <= bus_rdata_i;
            if (bus_err_i)
            begin
              bus_req_o        <= 1'b0;
              enq_entry.status <= STAT_GENERAL;
              enq              <= 1'b1;
              state            <= ST_SETTLE;
            end
            else
            begin
              bus_o.write <= 1'b1;
              bus_o.wdata <= (cur.data & cur.mask) | (bus_rdata_i & ~cur.mask);
              state       <= ST_BUS_WR;
            end
          end
        end
        ST_BUS_WR:
        begin
          if (bus_ack_i)
          begin
            bus_req_o       <= 1'b0;
            enq_entry.rdata <= old_data;
            if (bus_err_i)
              enq_entry.status <= STAT_GENERAL;
            else if (is_rmw_cur(cur.instr) && cur.cargo_big)
              enq_entry.status <= STAT_CARGO; // after the access
            enq   <= cur.instr[BIT_ACK];
            state <= ST_SETTLE;
          end
        end
        ST_TX_HDR:
        begin
          if (rep_ready_i)
          begin
            rep_hdr_valid_o <= 1'b0;
            remain          <= rep_hdr_o.len;
            bus_o.write     <= 1'b0;
            bus_o.addr      <= {rep_hdr_o.addr[31:2], 2'b00};
            bus_o.size      <= 3'h4;
            if (rep_hdr_o.status != STAT_OK || rep_hdr_o.instr[BIT_WRITE] ||
                rep_hdr_o.len == 24'h0)
            begin
              deq   <= 1'b1; // header only
              state <= ST_SETTLE;
            end
            else if (is_rmw_cur(rep_hdr_o.instr))
            begin
              rep_data_o       <= rep_hdr_o.rdata;
              rep_data_valid_o <= 1'b1;
              rep_last_o       <= 1'b1;
              remain           <= 24'h0;
              state            <= ST_TX_BT;
            end
            else
            begin
              bus_req_o <= 1'b1; // fetched on the fly
              state     <= ST_TX_RD;
            end
          end
        end
        ST_TX_RD:
        begin
          if (bus_ack_i)
          begin
            bus_req_o <= 1'b0;
            if (bus_err_i)
            begin
              rep_abort_o <= 1'b1; // truncated reply
              deq         <= 1'b1;
              state       <= ST_SETTLE;
            end
            else
            begin
              rep_data_o       <= bus_rdata_i;
              rep_data_valid_o <= 1'b1;
              rep_last_o       <= remain <= WORD_BYTES;
              remain           <= (remain <= WORD_BYTES) ? 24'h0 : remain - WORD_BYTES;
              if (rep_hdr_o.instr[BIT_INC])
                bus_o.addr <= bus_o.addr + ADDR_STEP;
              state <= ST_TX_BT;
            end
          end
        end
        ST_TX_BT:
        begin
          if (rep_ready_i)
          begin
            rep_data_valid_o <= 1'b0;
            rep_last_o       <= 1'b0;
            if (remain == 24'h0)
            begin
              deq   <= 1'b1;
              state <= ST_SETTLE;
            end
            else
            begin
              bus_req_o <= 1'b1;
              state     <= ST_TX_RD;
            end
          end
        end
        ST_SETTLE:
          state <= ST_IDLE; // lets the ring count catch up
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // read-modify-write code test on a stored instruction
  function automatic logic is_rmw_cur(input logic [7:0] ins);
    return !ins[BIT_WRITE] && ins[BIT_VERIFY] && ins[BIT_ACK] && ins[BIT_INC];
  endfunction

endmodule

/* File: verif/rtch_target_assertions.sv */
`timescale 1ns/100ps
module rtch_target_chk
  import rtch_pkg::*;
(
  // clock, reset, control
  input wire logic           mclk_i,
  input wire logic           rst_n_i,
  input wire logic           tgt_enable_i,
  input wire logic           buf_disable_i,
  // command side
  input wire rtch_cmd_type   cmd_i,
  input wire logic           cmd_ready_o,
  input wire logic           dma_fwd_o,
  // bus side
  input wire logic           bus_req_o,
  input wire rtch_bus_type   bus_o,
  input wire logic           bus_ack_i,
  // reply side
  input wire logic           rep_hdr_valid_o,
  input wire rtch_reply_type rep_hdr_o,
  input wire logic           rep_data_valid_o,
  input wire logic [31:0]    rep_data_o,
  input wire logic           rep_ready_i
);
  // ----------------------------------------------------------------
  // status of last accepted header
  // ----------------------------------------------------------------
  logic       err_hdr;
  logic       ack_q;
  logic [2:0] pend;

  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      err_hdr <= 1'b0;
    else if (rep_hdr_valid_o && rep_ready_i)
      err_hdr <= (rep_hdr_o.status != STAT_OK);

  // replies owed whose header has not yet been taken
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      ack_q <= 1'b0;
      pend  <= 3'h0;
    end
    else
    begin
      ack_q <= cmd_i.instr[BIT_ACK];
      pend  <= pend + {2'h0, cmd_ready_o && !dma_fwd_o && ack_q} -
               {2'h0, rep_hdr_valid_o && rep_ready_i};
    end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  AST_DIS_FWD: assert property (cmd_ready_o && !$past(tgt_enable_i) |-> dma_fwd_o)
    else $error("disabled target kept a packet");
  AST_RESP_FWD: assert property (cmd_ready_o && !$past(cmd_i.instr[BIT_CMD]) |-> dma_fwd_o)
    else $error("response packet not forwarded");
  AST_FWD_CAUSE: assert property (dma_fwd_o |-> cmd_ready_o &&
      (!$past(tgt_enable_i) || !$past(cmd_i.instr[BIT_CMD])))
    else $error("command forwarded while enabled");
  AST_READY_PULSE: assert property (cmd_ready_o |=> !cmd_ready_o)
    else $error("command accept longer than one cycle");
  AST_BUS_SHAPE: assert property (bus_req_o |-> (bus_o.size inside {3'h1, 3'h2, 3'h4}) &&
      ((bus_o.addr[1:0] & (bus_o.size[1:0] - 2'h1)) == 2'h0))
    else $error("bus access size or alignment illegal");
  AST_REQ_HOLD: assert property (bus_req_o && !bus_ack_i |=> bus_req_o && $stable(bus_o))
    else $error("bus request changed before ack");
  AST_HDR_HOLD: assert property (rep_hdr_valid_o && !rep_ready_i |=>
      rep_hdr_valid_o && $stable(rep_hdr_o))
    else $error("reply header changed while stalled");
  AST_ERR_NODATA: assert property (rep_data_valid_o |-> !err_hdr)
    else $error("data sent after error header");
  AST_DIS_ONE: assert property (buf_disable_i && cmd_ready_o |-> !rep_hdr_valid_o && pend == 3'h0)
    else $error("command taken with reply pending");

  // main scenarios
  cover property (dma_fwd_o);
  cover property (rep_hdr_valid_o && rep_ready_i && rep_hdr_o.status != STAT_OK);
  cover property (bus_req_o && bus_ack_i && bus_o.write);
endmodule

bind rtch_target rtch_target_chk prop_mon (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .tgt_enable_i(tgt_enable_i),
  .buf_disable_i(buf_disable_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
  .dma_fwd_o(dma_fwd_o), .bus_req_o(bus_req_o), .bus_o(bus_o), .bus_ack_i(bus_ack_i),
  .rep_hdr_valid_o(rep_hdr_valid_o), .rep_hdr_o(rep_hdr_o),
  .rep_data_valid_o(rep_data_valid_o), .rep_data_o(rep_data_o), .rep_ready_i(rep_ready_i));

/* File: verif/rtch_bus_model.sv */
`timescale 1ns/100ps
module rtch_bus_model
  import rtch_pkg::*;
(
  // clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  // request side
  input  wire logic         req_i,
  input  wire rtch_bus_type bus_i,
  input  wire logic         slow_i,
  // answer side
  output logic              ack_o,
  output logic              err_o,
  output logic [31:0]       rdata_o
);
  logic [31:0] mem [0:15];
  logic [1:0]  wait_cnt;

  // memory with prompt or slow ack, data toggles outside ack
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      ack_o    <= 1'b0;
      err_o    <= 1'b0;
      rdata_o  <= 32'h0;
      wait_cnt <= 2'h0;
      for (int i = 0; i < 16; i++)
        mem[i] <= 32'h0;
    end
    else
    begin
      ack_o   <= 1'b0;
      err_o   <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o)
      begin
        if (wait_cnt >= (slow_i ? 2'h3 : 2'h0))
        begin
          ack_o    <= 1'b1;
          err_o    <= bus_i.addr[31];
          rdata_o  <= mem[bus_i.addr[5:2]];
          wait_cnt <= 2'h0;
          if (bus_i.write)
            mem[bus_i.addr[5:2]] <= bus_i.wdata;
        end
        else
          wait_cnt <= wait_cnt + 2'h1;
      end
    end
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/100ps
module testbench;
  import rtch_pkg::*;

  logic           mclk_i = 0, rst_n_i = 0, tgt_enable_i = 1, buf_disable_i = 0;
  logic           cmd_valid_i = 0, rep_ready_i = 0, slow = 0, fwd;
  logic [7:0]     dest_key_i = 8'h00, kx = 8'h00;
  rtch_cmd_type   cmd_i = '0;
  logic           cmd_ready_o, dma_fwd_o, bus_req_o, bus_ack_i, bus_err_i;
  logic           rep_hdr_valid_o, rep_data_valid_o, rep_last_o, rep_abort_o;
  logic [31:0]    bus_rdata_i, rep_data_o, d0, d1, m, a;
  rtch_bus_type   bus_o;
  rtch_reply_type rep_hdr_o;
  rtch_reply_type hq[$];
  logic [31:0]    dq[$];
  logic           lq[$];
  logic [7:0]     uc[4] = '{8'h40, 8'h44, 8'h50, 8'h54};
  int             err_count = 0, n_checks = 0, nbus = 0, n, nab = 0;

  always #2 mclk_i = ~mclk_i;

  rtch_target dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .tgt_enable_i(tgt_enable_i),
    .buf_disable_i(buf_disable_i), .dest_key_i(dest_key_i), .cmd_valid_i(cmd_valid_i),
    .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .dma_fwd_o(dma_fwd_o), .bus_req_o(bus_req_o),
    .bus_o(bus_o), .bus_ack_i(bus_ack_i), .bus_err_i(bus_err_i), .bus_rdata_i(bus_rdata_i),
    .rep_hdr_valid_o(rep_hdr_valid_o), .rep_hdr_o(rep_hdr_o),
    .rep_data_valid_o(rep_data_valid_o), .rep_data_o(rep_data_o), .rep_last_o(rep_last_o),
    .rep_abort_o(rep_abort_o), .rep_ready_i(rep_ready_i));

  rtch_bus_model mem (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(bus_req_o), .bus_i(bus_o),
    .slow_i(slow), .ack_o(bus_ack_i), .err_o(bus_err_i), .rdata_o(bus_rdata_i));

  // ----------------------------------------------------------------
  // reply sink with random stalls, reply and bus monitor
  // ----------------------------------------------------------------
  always @(posedge mclk_i)
  begin
    #1;
    rep_ready_i = ($urandom_range(3) != 0);
  end

  always @(posedge mclk_i)
  begin
    if (rep_hdr_valid_o && rep_ready_i) hq.push_back(rep_hdr_o);
    if (rep_data_valid_o && rep_ready_i) dq.push_back(rep_data_o);
    if (rep_data_valid_o && rep_ready_i) lq.push_back(rep_last_o);
    if (rep_abort_o) nab++;
    if (bus_req_o && bus_ack_i) nbus++;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task tick;
    @(posedge mclk_i);
    #1;
  endtask

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      $display("FAIL %s expected %h seen %h", nm, e, s);
      err_count++;
    end
  endtask

  task complete_run;
    if (err_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // expected word after a masked update
  function automatic logic [31:0] merged(input logic [31:0] nw, input logic [31:0] od,
                                         input logic [31:0] mk);
    return (nw & mk) | (od & ~mk);
  endfunction

  // one command, held until accepted, then a settle cycle
  task send(input logic [7:0] ins, input logic [31:0] ad, input logic [23:0] l,
            input logic [31:0] d, input logic [31:0] mk, input logic cb);
    int k;
    k = 0;
    cmd_i = '{ins, dest_key_i ^ kx, ad, l, d, mk, cb};
    slow = $urandom_range(1);
    cmd_valid_i = 1'b1;
    while (cmd_ready_o !== 1'b1 && k < 500)
    begin
      tick;
      k++;
    end
    fwd = dma_fwd_o;
    cmd_valid_i = 1'b0;
    tick;
  endtask

  // next reply: status and optional single data word
  task rep(input logic [7:0] st, input int nd, input logic [31:0] d);
    int k;
    rtch_reply_type h;
    k = 0;
    h = '1;
    while (hq.size() == 0 && k < 400)
    begin
      tick;
      k++;
    end
    if (hq.size() > 0) h = hq.pop_front();
    chk("status", h.status, st);
    if (nd == 0) repeat (20) tick;
    while (nd > 0 && dq.size() == 0 && k < 800)
    begin
      tick;
      k++;
    end
    if (nd == 0) chk("no data", dq.size(), 0);
    else chk("data", (dq.size() > 0) ? dq.pop_front() : ~d, d);
    if (nd > 0) chk("last", (lq.size() > 0) ? lq.pop_front() : 1'b0, 1);
  endtask

  task no_rep;
    repeat (40) tick;
    chk("no reply", hq.size() + dq.size(), 0);
  endtask

  initial
  begin
    #200000;
    err_count++;
    complete_run;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h0c17));
    repeat (3) tick;
    rst_n_i = 1'b1;
    dest_key_i = $urandom;
    d0 = $urandom;
    d1 = $urandom;
    m = $urandom;
    send(8'h6c, 32'h10, 24'h4, d0, 0, 0); rep(STAT_OK, 0, 0);
    send(8'h4c, 32'h10, 24'h4, 0, 0, 0); rep(STAT_OK, 1, d0);
    send(8'h48, 32'h12, 24'h4, 0, 0, 0); rep(STAT_AUTH, 0, 0);
    send(8'h48, 32'h10, 24'h3, 0, 0, 0); rep(STAT_AUTH, 0, 0);
    send(8'h48, 32'h10, 24'h4, 0, 0, 0); rep(STAT_OK, 1, d0);
    n = nbus;
    foreach (uc[i]) send(uc[i], 32'h10, 24'h4, 0, 0, 0);
    no_rep;
    send(8'h5c, 32'h10, RMW_LEN_BAD, d1, m, 0); rep(STAT_RMW_LEN, 0, 0);
    send(8'h5c, 32'h12, RMW_LEN_8, d1, m, 0); rep(STAT_AUTH, 0, 0);
    send(8'h78, 32'h10, 24'h8, d1, 0, 0); rep(STAT_VER_OVR, 0, 0);
    send(8'h78, 32'h12, 24'h4, d1, 0, 0); rep(STAT_AUTH, 0, 0);
    send(8'h58, 32'h10, 24'h4, 0, 0, 0); rep(STAT_UNUSED, 0, 0);
    chk("bus count", nbus, n);
    send(8'h5c, 32'h10, RMW_LEN_8, d1, m, 0); rep(STAT_OK, 1, d0);
    d0 = merged(d1, d0, m);
    send(8'h4c, 32'h10, 24'h4, 0, 0, 0); rep(STAT_OK, 1, d0);
    send(8'h5c, 32'h10, RMW_LEN_8, d1, ~m, 1); rep(STAT_CARGO, 0, 0);
    d0 = merged(d1, d0, ~m);
    send(8'h4c, 32'h10, 24'h4, 0, 0, 0); rep(STAT_OK, 1, d0);
    kx = 8'h01 | $urandom;
    send(8'h4c, 32'h10, 24'h4, 0, 0, 0); rep(STAT_KEY, 0, 0);
    kx = 8'h00;
    tgt_enable_i = 1'b0;
    send(8'h4c, 32'h10, 24'h4, 0, 0, 0); chk("forward", fwd, 1);
    no_rep;
    tgt_enable_i = 1'b1;
    send(8'h0c, 32'h10, 24'h4, 0, 0, 0); chk("forward", fwd, 1);
    no_rep;
    // read then write to same word, single entry keeps order
    buf_disable_i = 1'b1;
    send(8'h6c, 32'h20, 24'h4, d1, 0, 0); rep(STAT_OK, 0, 0);
    send(8'h4c, 32'h20, 24'h4, 0, 0, 0);
    send(8'h6c, 32'h20, 24'h4, d0, 0, 0);
    rep(STAT_OK, 1, d1);
    rep(STAT_OK, 0, 0);
    // random write and readback, buffer mode random
    repeat (8)
    begin
      a = {26'h0, 4'($urandom_range(15)), 2'h0};
      d1 = $urandom;
      buf_disable_i = $urandom_range(1);
      send(8'h6c, a, 24'h4, d1, 0, 0); rep(STAT_OK, 0, 0);
      send(8'h4c, a, 24'h4, 0, 0, 0); rep(STAT_OK, 1, d1);
    end
    // several reads queued before any reply is taken
    buf_disable_i = 1'b0;
    send(8'h4c, a, 24'h4, 0, 0, 0);
    send(8'h48, a, 24'h4, 0, 0, 0);
    send(8'h4c, a, 24'h4, 0, 0, 0);
    repeat (3) rep(STAT_OK, 1, d1);
    // bus errors: failed read-modify-write, and a read cut short on the fly
    send(8'h5c, 32'h80000010, RMW_LEN_8, d1, m, 0); rep(STAT_GENERAL, 0, 0);
    send(8'h4c, 32'h80000010, 24'h4, 0, 0, 0); rep(STAT_OK, 0, 0);
    chk("abort", nab, 1);
    complete_run;
  end
endmodule
